// ===== hw/iqgpd_map.svh
// Register offsets, field positions, reset values and sizes of the IQ gain, phase and delay bank.
`ifndef IQGPD_MAP_SVH
`define IQGPD_MAP_SVH
`define IQGPD_OFS_GAIN_C      5'h0e
`define IQGPD_OFS_GAIN_D_DLY  5'h0f
`define IQGPD_OFS_PHASE_AB    5'h10
`define IQGPD_RST_GAIN        11'h400
`define IQGPD_RST_PHASE       12'h000
`define IQGPD_RST_DLY         2'h0
`define IQGPD_GAIN_HI         10
`define IQGPD_PHASE_HI        11
`define IQGPD_DLY_AB_HI       15
`define IQGPD_DLY_AB_LO       14
`define IQGPD_DLY_CD_HI       13
`define IQGPD_DLY_CD_LO       12
`define IQGPD_GAIN_FRAC       10
`define IQGPD_PHASE_FRAC      12
`define IQGPD_RESV_GAIN_D     11
`define IQGPD_MAX_DLY         3
`endif

// ===== hw/iqgpd_pkg.sv
// Types shared by the IQ gain, phase and delay bank.
package iqgpd_pkg;
  typedef struct packed {
    logic [10:0] gain_c;
    logic [10:0] gain_d;
    logic [11:0] phase_ab;
  } iqgpd_corr_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    logic [15:0] d;
  } iqgpd_samples_t;
endpackage : iqgpd_pkg

// ===== hw/iqgpd_regs.sv
// Gain C/D, pair output delay and AB phase registers with the correction datapath they steer.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "iqgpd_map.svh"

module iqgpd_regs (
  input  wire logic                   SYS_CLK_IN,     // 10 MHz clock
  input  wire logic                   RST_N_IN,       // Async reset, active low
  input  wire logic [4:0]             ADDR_IN,        // Register index
  input  wire logic [15:0]            WDATA_IN,       // Write data
  input  wire logic                   WR_IN,          // Write strobe
  input  wire logic                   RD_IN,          // Read strobe
  input  wire logic                   AUTOSYNC_EN_IN, // Auto-sync enable level
  input  wire iqgpd_pkg::iqgpd_samples_t SAMPLE_IN,   // Input samples A-D
  output logic [15:0]                 RDATA_OUT,      // Read data, one cycle later
  output iqgpd_pkg::iqgpd_samples_t   SAMPLE_OUT      // Corrected A, C and D with uncorrected B, delayed
);

  // ----------------------------------------------------------------------
  // Staged registers and bus decode
  // ----------------------------------------------------------------------
  logic [10:0]            gain_corr_chan_c;
  logic [10:0]            gain_corr_chan_d;
  logic [1:0]             pair_ab_out_latency;
  logic [1:0]             pair_cd_out_latency;
  logic [11:0]            phase_corr_pair_ab;
  iqgpd_pkg::iqgpd_corr_t active;
  logic                   autosync_en_s1;
  logic                   autosync_en;

  wire wr_gain_c  = WR_IN && (ADDR_IN == `IQGPD_OFS_GAIN_C);
  wire wr_gain_d  = WR_IN && (ADDR_IN == `IQGPD_OFS_GAIN_D_DLY);
  wire wr_phase   = WR_IN && (ADDR_IN == `IQGPD_OFS_PHASE_AB);
  wire do_sync    = wr_phase && autosync_en;

  // Reserved bits are neither stored nor driven, so they read as zero.
  wire [15:0] rd_gain_c = {5'h00, gain_corr_chan_c};
  wire [15:0] rd_gain_d = {pair_ab_out_latency, pair_cd_out_latency, 1'b0, gain_corr_chan_d};
  wire [15:0] rd_phase  = {4'h0, phase_corr_pair_ab};
  wire [15:0] next_rdata = (ADDR_IN == `IQGPD_OFS_GAIN_C)     ? rd_gain_c :
                           (ADDR_IN == `IQGPD_OFS_GAIN_D_DLY) ? rd_gain_d :
                           (ADDR_IN == `IQGPD_OFS_PHASE_AB)   ? rd_phase  : 16'h0000;

  // The enable is a pin level, so it is synchronised before use.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      autosync_en_s1 <= 1'b0;
      autosync_en    <= 1'b0;
    end else begin
      autosync_en_s1 <= AUTOSYNC_EN_IN;
      autosync_en    <= autosync_en_s1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gain_corr_chan_c    <= `IQGPD_RST_GAIN;
      gain_corr_chan_d    <= `IQGPD_RST_GAIN;
      pair_ab_out_latency <= `IQGPD_RST_DLY;
      pair_cd_out_latency <= `IQGPD_RST_DLY;
      phase_corr_pair_ab  <= `IQGPD_RST_PHASE;
    end else begin
      if (wr_gain_c) begin
        gain_corr_chan_c <= WDATA_IN[`IQGPD_GAIN_HI:0];
      end
      if (wr_gain_d) begin
        gain_corr_chan_d    <= WDATA_IN[`IQGPD_GAIN_HI:0];
        pair_ab_out_latency <= WDATA_IN[`IQGPD_DLY_AB_HI:`IQGPD_DLY_AB_LO];
        pair_cd_out_latency <= WDATA_IN[`IQGPD_DLY_CD_HI:`IQGPD_DLY_CD_LO];
      end
      if (wr_phase) begin
        phase_corr_pair_ab <= WDATA_IN[`IQGPD_PHASE_HI:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (RD_IN) begin
      RDATA_OUT <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Active correction set, loaded only by auto-sync
  // ----------------------------------------------------------------------
  // The phase takes the bus word directly so that all three values land in the same edge.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      active.gain_c   <= `IQGPD_RST_GAIN;
      active.gain_d   <= `IQGPD_RST_GAIN;
      active.phase_ab <= `IQGPD_RST_PHASE;
    end else if (do_sync) begin
      active.gain_c   <= gain_corr_chan_c;
      active.gain_d   <= gain_corr_chan_d;
      active.phase_ab <= WDATA_IN[`IQGPD_PHASE_HI:0];
    end
  end

  // ----------------------------------------------------------------------
  // Correction arithmetic
  // ----------------------------------------------------------------------
  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh00007fff) begin
      sat16 = 16'h7fff;
    end else if (v < -32'sh00008000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // Unsigned 1.10 gain times a signed sample.
  function automatic logic [15:0] gain_mul(input logic [15:0] s, input logic [10:0] g);
    logic signed [31:0] p;
    p = $signed({{16{s[15]}}, s}) * $signed({21'h00000, g});
    gain_mul = sat16(p >>> `IQGPD_GAIN_FRAC);
  endfunction : gain_mul

  // The phase word counts in steps of 1/4096, so its span is -0.5 up to just under 0.5.
  wire signed [31:0] phase_prod = $signed({{16{SAMPLE_IN.b[15]}}, SAMPLE_IN.b}) *
                                  $signed({{20{active.phase_ab[11]}}, active.phase_ab});
  wire signed [31:0] a_sum = $signed({{16{SAMPLE_IN.a[15]}}, SAMPLE_IN.a}) +
                             (phase_prod >>> `IQGPD_PHASE_FRAC);
  wire [15:0] corr_a = sat16(a_sum);
  wire [15:0] corr_c = gain_mul(SAMPLE_IN.c, active.gain_c);
  wire [15:0] corr_d = gain_mul(SAMPLE_IN.d, active.gain_d);

  // ----------------------------------------------------------------------
  // Pair delay lines
  // ----------------------------------------------------------------------
  logic [31:0] ab_line [0:`IQGPD_MAX_DLY];
  logic [31:0] cd_line [0:`IQGPD_MAX_DLY];

  // Both channels of a pair share one line, so their alignment cannot drift.
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i <= `IQGPD_MAX_DLY; i++) begin
        ab_line[i] <= 32'h00000000;
        cd_line[i] <= 32'h00000000;
      end
    end else begin
      ab_line[0] <= {corr_a, SAMPLE_IN.b};
      cd_line[0] <= {corr_c, corr_d};
      for (int i = 1; i <= `IQGPD_MAX_DLY; i++) begin
        ab_line[i] <= ab_line[i-1];
        cd_line[i] <= cd_line[i-1];
      end
    end
  end

  wire [31:0] ab_sel = ab_line[pair_ab_out_latency];
  wire [31:0] cd_sel = cd_line[pair_cd_out_latency];

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SAMPLE_OUT <= '0;
    end else begin
      SAMPLE_OUT <= {ab_sel, cd_sel};
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  gain_staging_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    !do_sync |=> $stable(active)
  ) else $error("active set changed without sync");

  sync_load_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    do_sync |=> active.gain_c == $past(gain_corr_chan_c) &&
                active.phase_ab == $past(WDATA_IN[`IQGPD_PHASE_HI:0])
  ) else $error("sync load wrong");

  sync_gain_d_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    do_sync |=> active.gain_d == $past(gain_corr_chan_d)
  ) else $error("sync load of gain d wrong");

  gain_c_store_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    wr_gain_c |=> gain_corr_chan_c == $past(WDATA_IN[`IQGPD_GAIN_HI:0])
  ) else $error("gain c store");

  gain_d_store_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    wr_gain_d |=> gain_corr_chan_d == $past(WDATA_IN[`IQGPD_GAIN_HI:0])
  ) else $error("gain d store");

  dly_ab_store_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    wr_gain_d |=> pair_ab_out_latency == $past(WDATA_IN[`IQGPD_DLY_AB_HI:`IQGPD_DLY_AB_LO])
  ) else $error("ab delay");

  dly_cd_store_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    wr_gain_d |=> pair_cd_out_latency == $past(WDATA_IN[`IQGPD_DLY_CD_HI:`IQGPD_DLY_CD_LO])
  ) else $error("cd delay");

  phase_read_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    RD_IN && ADDR_IN == `IQGPD_OFS_PHASE_AB |=> RDATA_OUT == 16'(phase_corr_pair_ab)
  ) else $error("phase readback");

  resv_zero_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    RD_IN && ADDR_IN == `IQGPD_OFS_GAIN_D_DLY |=> RDATA_OUT[`IQGPD_RESV_GAIN_D] == 1'b0
  ) else $error("reserved bit set");

  // Unmapped indices must read as zero so that software can probe the bank safely.
  unmapped_read_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    RD_IN && !(ADDR_IN inside {`IQGPD_OFS_GAIN_C, `IQGPD_OFS_GAIN_D_DLY, `IQGPD_OFS_PHASE_AB})
    |=> RDATA_OUT == 16'h0000
  ) else $error("unmapped read not zero");

  zero_phase_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    active.phase_ab == 12'h000 |-> corr_a == SAMPLE_IN.a
  ) else $error("phase leak");

  // The reset guards keep the delay lines' cleared contents out of the comparison.
  pair_align_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    pair_ab_out_latency == 2'h0 && $stable(pair_ab_out_latency) && $past(RST_N_IN) |=>
    SAMPLE_OUT.b == $past(SAMPLE_IN.b, 2)
  ) else $error("ab pair latency");

  cd_align_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    pair_cd_out_latency == 2'h0 && $past(RST_N_IN) |=>
    SAMPLE_OUT.c == $past(corr_c, 2) && SAMPLE_OUT.d == $past(corr_d, 2)
  ) else $error("cd pair latency");

  ab_max_delay_a: assert property (
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    pair_ab_out_latency == 2'(`IQGPD_MAX_DLY) && $past(RST_N_IN, 4) |=>
    SAMPLE_OUT.a == $past(corr_a, 5) && SAMPLE_OUT.b == $past(SAMPLE_IN.b, 5)
  ) else $error("ab longest delay");

endmodule : iqgpd_regs

// ===== verif/iqgpd_regs_tb.sv
// Self-checking testbench for the IQ gain, phase and delay register bank.
`timescale 1ns/1ps
module iqgpd_regs_tb;
  logic                      clk        = 1'b0;
  logic                      rst_n      = 1'b0;
  logic [4:0]                addr       = 5'h00;
  logic [15:0]               wdata      = 16'h0000;
  logic                      wr         = 1'b0;
  logic                      rd         = 1'b0;
  logic                      sync_en    = 1'b0;
  iqgpd_pkg::iqgpd_samples_t smp        = '0;
  logic [15:0]               rdata;
  iqgpd_pkg::iqgpd_samples_t out;
  int                        n_mismatch = 0;
  int                        n_compared = 0;
  int                        lat[4];
  localparam int             base_lat   = 2; // First delay-line stage plus output register.

  always #50 clk = ~clk;

  iqgpd_regs u_dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .AUTOSYNC_EN_IN(sync_en), .SAMPLE_IN(smp), .RDATA_OUT(rdata),
    .SAMPLE_OUT(out));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt

  // A gap cycle follows each strobe so no strobe is lowered and raised in one step.
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk_word(rdata, exp);
    @(posedge clk);
  endtask : rd_reg

  function automatic logic [15:0] chan(input int i);
    return out[63-16*i -: 16];
  endfunction : chan

  task automatic settle(input logic [63:0] exp);
    repeat (10) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) chk_word(chan(i), exp[63-16*i -: 16]);
    @(posedge clk);
  endtask : settle

  // Steps all inputs and records the cycle at which each output first shows the new value.
  task automatic step(input logic [15:0] v);
    smp <= {v, v, v, v};
    for (int i = 0; i < 4; i++) lat[i] = -1;
    for (int k = 1; k < 16; k++) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) if (lat[i] < 0 && chan(i) === v) lat[i] = k;
    end
    @(posedge clk);
  endtask : step

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    smp   <= {4{16'h0100}};
    @(posedge clk);
    rd_reg(5'h0e, 16'h0400);
    rd_reg(5'h0f, 16'h0400);
    rd_reg(5'h10, 16'h0000);
    rd_reg(5'h1f, 16'h0000);
    wr_reg(5'h0e, 16'hffff);
    rd_reg(5'h0e, 16'h07ff);
    wr_reg(5'h0f, 16'hffff);
    rd_reg(5'h0f, 16'hf7ff);
    wr_reg(5'h10, 16'hffff);
    rd_reg(5'h10, 16'h0fff);
    settle({4{16'h0100}});
    for (int d = 0; d < 4; d++) begin
      wr_reg(5'h0f, {d[1:0], 2'(3 - d), 12'h400});
      step(d[0] ? 16'h0100 : 16'h0200);
      chk_cnt(lat[0], base_lat + d);
      chk_cnt(lat[1], lat[0]);
      chk_cnt(lat[2], base_lat + 3 - d);
      chk_cnt(lat[3], lat[2]);
    end
    smp <= {16'h0100, 16'h1000, 16'h1000, 16'h1000};
    wr_reg(5'h0e, 16'h0200);
    wr_reg(5'h0f, 16'h0600);
    wr_reg(5'h10, 16'h0400);
    settle({16'h0100, 16'h1000, 16'h1000, 16'h1000});
    sync_en <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(5'h10, 16'h0400);
    settle({16'h0500, 16'h1000, 16'h0800, 16'h1800});
    wr_reg(5'h10, 16'h0c00);
    settle({16'hfd00, 16'h1000, 16'h0800, 16'h1800});
    final_report();
  end
endmodule : iqgpd_regs_tb
